// ### hdl/tac_pkg.sv
// Constants, register map and carrier types for the timer contention arbiter
// ---------------------------------------------------------------------------
// How it works
// - A counter clear in the commit state of a counter write wins; the written value is lost.
// - An increment in the commit state of a word counter write is skipped; the written value loads.
// - An increment in the strobe or commit state of a byte counter write is skipped; the other byte holds.
// - A compare match in the commit state of a compare/capture write is suppressed; the write completes.
// - An overflow in the commit state of a counter write loads the written value but still sets the overflow flag.
// - A capture during the read state of a compare/capture read returns the value held before the capture.
// - A clearing capture together with an increment clears without incrementing and stores the old count.
// - A capture in the commit state of a compare/capture write performs the capture and drops the write.
// - Compare-match clearing acts on the last tick at which the count equals the register, giving N + 1 counts.
// - A buffered capture in the commit state of a buffer write performs the buffer transfer and drops the write.
// - A byte write to a synchronized counter gives every synchronized counter the full 16-bit addressed value.
// - A capture that clears the counter at its maximum value signals no overflow.
// ---------------------------------------------------------------------------
package tac_pkg;
  localparam int NUM_CH = 5;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int CH_W = 3;
  localparam int STAT_W = 2 * NUM_CH;

  // Address fields
  localparam int GLOBAL_BIT = 8;
  localparam int CH_LSB = 5;
  localparam int CH_MSB = 7;
  localparam int REG_MSB = 4;

  // Per-channel register offsets, channel stride 0x20
  localparam logic [4:0] REG_COUNT = 5'h00;
  localparam logic [4:0] REG_COUNT_HI = 5'h04;
  localparam logic [4:0] REG_COUNT_LO = 5'h08;
  localparam logic [4:0] REG_GR = 5'h0C;
  localparam logic [4:0] REG_BR = 5'h10;
  localparam logic [4:0] REG_CTRL = 5'h14;

  // Global register offsets
  localparam logic [8:0] REG_RUN = 9'h100;
  localparam logic [8:0] REG_FUNC = 9'h104;
  localparam logic [8:0] REG_PRESCALE = 9'h108;
  localparam logic [8:0] REG_STATUS = 9'h10C;
  localparam logic [8:0] REG_MASK = 9'h110;

  // Channel control fields
  localparam int CTRL_W = 5;
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam int CTRL_BUFFER_BIT = 1;
  localparam int CTRL_CLR_CM_BIT = 2;
  localparam int CTRL_CLR_CAP_BIT = 3;
  localparam int CTRL_SYNC_BIT = 4;

  // Function control fields
  localparam int FUNC_W = 2;
  localparam int FUNC_MODE_LO_BIT = 0;
  localparam int FUNC_MODE_HI_BIT = 1;

  // Prescaler
  localparam int PRESCALE_W = 2;
  localparam int PRE_CNT_W = 8;

  // Status layout: match/capture flags low, overflow flags above
  localparam int STAT_OVF_LSB = NUM_CH;

  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] GR_RESET = 16'hFFFF;
  localparam logic [15:0] BR_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [NUM_CH-1:0] RUN_RESET = 5'h00;
  localparam logic [FUNC_W-1:0] FUNC_RESET = 2'h0;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 2'h0;
  localparam logic [STAT_W-1:0] STAT_RESET = 10'h000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tac_bus_req_type;
endpackage

// ### hdl/tac_top.sv
// Multi-channel 16-bit timer with access/event contention arbitration
`timescale 1ns/10ps
`default_nettype none
module tac_top (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire tac_pkg::tac_bus_req_type bus_req_in,
  input wire logic [tac_pkg::NUM_CH-1:0] capture_pin_in,
  output logic [tac_pkg::DATA_W-1:0] rdata_out,
  output logic [tac_pkg::NUM_CH-1:0] compare_match_out,
  output logic irq_out
);
  import tac_pkg::*;

  // ---------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------
  logic rstn_q1;
  logic rstn_sync;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rstn_q1 <= 1'b0;
      rstn_sync <= 1'b0;
    end else begin
      rstn_q1 <= 1'b1;
      rstn_sync <= rstn_q1;
    end
  end

  // ---------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------
  logic [15:0] timer_count [NUM_CH];
  logic [15:0] compare_capture_reg [NUM_CH];
  logic [15:0] buffer_reg [NUM_CH];
  logic [CTRL_W-1:0] ctrl [NUM_CH];
  logic [NUM_CH-1:0] channel_run_reg;
  logic [FUNC_W-1:0] function_control_reg;
  logic [PRESCALE_W-1:0] prescale;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [NUM_CH-1:0] match_set;
  logic [NUM_CH-1:0] ovf_set;
  logic [NUM_CH-1:0] sync_sel;

  // ---------------------------------------------------------------------
  // Write pipeline: strobe cycle is the second state, commit is the third
  // ---------------------------------------------------------------------
  logic wp;
  logic [ADDR_W-1:0] wp_addr;
  logic [DATA_W-1:0] wp_data;

  always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      wp <= 1'b0;
      wp_addr <= '0;
      wp_data <= '0;
    end else begin
      wp <= bus_req_in.wr;
      wp_addr <= bus_req_in.addr;
      wp_data <= bus_req_in.wdata;
    end
  end

  logic [CH_W-1:0] wp_ch;
  logic [4:0] wp_reg;
  logic wp_on_ch;
  logic [CH_W-1:0] wsel;
  logic wr_cnt_any;
  logic [15:0] write_val;
  logic sync_hit;
  logic [CH_W-1:0] st_ch;
  logic [4:0] st_reg;
  logic st_byte;

  assign wp_ch = wp_addr[CH_MSB:CH_LSB];
  assign wp_reg = wp_addr[REG_MSB:0];
  assign wp_on_ch = wp && !wp_addr[GLOBAL_BIT] && (wp_ch < CH_W'(NUM_CH));
  assign wsel = (wp_ch < CH_W'(NUM_CH)) ? wp_ch : '0;
  assign wr_cnt_any = wp_on_ch && (wp_reg == REG_COUNT
    || wp_reg == REG_COUNT_HI || wp_reg == REG_COUNT_LO);
  assign sync_hit = wr_cnt_any && sync_sel[wsel];

  // Byte writes merge with the addressed counter's other byte
  always_comb begin
    case (wp_reg)
      REG_COUNT_HI: write_val = {wp_data[7:0], timer_count[wsel][7:0]};
      REG_COUNT_LO: write_val = {timer_count[wsel][15:8], wp_data[7:0]};
      default: write_val = wp_data;
    endcase
  end

  // Strobe-cycle decode for byte counter writes
  assign st_ch = bus_req_in.addr[CH_MSB:CH_LSB];
  assign st_reg = bus_req_in.addr[REG_MSB:0];
  assign st_byte = bus_req_in.wr && !bus_req_in.addr[GLOBAL_BIT]
    && (st_reg == REG_COUNT_HI || st_reg == REG_COUNT_LO);

  // ---------------------------------------------------------------------
  // Prescaler: shared counter tick
  // ---------------------------------------------------------------------
  logic [PRE_CNT_W-1:0] pre_cnt;
  logic [PRE_CNT_W-1:0] pre_mask;
  logic tick;

  always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + PRE_CNT_W'(1);
    end
  end

  assign pre_mask = PRE_CNT_W'((1 << prescale) - 1);
  assign tick = ((pre_cnt & pre_mask) == pre_mask);

  // ---------------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic cap_q1;
    logic cap_q2;
    logic cap_q3;
    logic own_cnt;
    logic own_gr;
    logic own_br;
    logic own_ctrl;
    logic byte_t2;
    logic inc;
    logic cap;
    logic cm;
    logic clr;
    logic cap_mode;
    logic buf_en;

    // Pin passes two flops before any edge logic looks at it
    always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
      if (!rstn_sync) begin
        cap_q1 <= 1'b0;
        cap_q2 <= 1'b0;
        cap_q3 <= 1'b0;
      end else begin
        cap_q1 <= capture_pin_in[i];
        cap_q2 <= cap_q1;
        cap_q3 <= cap_q2;
      end
    end

    assign cap_mode = ctrl[i][CTRL_CAPTURE_BIT];
    assign buf_en = ctrl[i][CTRL_BUFFER_BIT];
    assign sync_sel[i] = ctrl[i][CTRL_SYNC_BIT];
    assign own_cnt = wr_cnt_any && (wsel == CH_W'(i));
    assign own_gr = wp_on_ch && (wsel == CH_W'(i)) && (wp_reg == REG_GR);
    assign own_br = wp_on_ch && (wsel == CH_W'(i)) && (wp_reg == REG_BR);
    assign own_ctrl = wp_on_ch && (wsel == CH_W'(i)) && (wp_reg == REG_CTRL);
    assign byte_t2 = st_byte && (st_ch == CH_W'(i));
    assign inc = tick && channel_run_reg[i];
    assign cap = cap_q2 && !cap_q3 && cap_mode;
    // Match fires as the count leaves the matching value
    assign cm = inc && !cap_mode
      && (timer_count[i] == compare_capture_reg[i])
      && !own_gr;
    assign clr = (cap && ctrl[i][CTRL_CLR_CAP_BIT])
      || (cm && ctrl[i][CTRL_CLR_CM_BIT]);
    // Overflow seen even when a write replaces the increment
    assign ovf_set[i] = inc && !clr && (timer_count[i] == COUNT_MAX);
    assign match_set[i] = cm || cap;

    always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
      if (!rstn_sync) begin
        timer_count[i] <= COUNT_RESET;
      end else if (clr) begin
        timer_count[i] <= COUNT_RESET;
      end else if (sync_hit && sync_sel[i]) begin
        timer_count[i] <= write_val;
      end else if (own_cnt) begin
        timer_count[i] <= write_val;
      end else if (inc && !byte_t2) begin
        timer_count[i] <= timer_count[i] + 16'h0001;
      end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
      if (!rstn_sync) begin
        compare_capture_reg[i] <= GR_RESET;
      end else if (cap) begin
        compare_capture_reg[i] <= timer_count[i];
      end else if (cm && buf_en) begin
        compare_capture_reg[i] <= buffer_reg[i];
      end else if (own_gr) begin
        compare_capture_reg[i] <= wp_data;
      end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
      if (!rstn_sync) begin
        buffer_reg[i] <= BR_RESET;
      end else if (cap && buf_en) begin
        buffer_reg[i] <= compare_capture_reg[i];
      end else if (own_br) begin
        buffer_reg[i] <= wp_data;
      end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
      if (!rstn_sync) begin
        ctrl[i] <= CTRL_RESET;
      end else if (own_ctrl) begin
        ctrl[i] <= wp_data[CTRL_W-1:0];
      end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
      if (!rstn_sync) begin
        compare_match_out[i] <= 1'b0;
      end else begin
        compare_match_out[i] <= cm;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------------
  logic wp_glob;

  assign wp_glob = wp && wp_addr[GLOBAL_BIT];

  always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      channel_run_reg <= RUN_RESET;
      function_control_reg <= FUNC_RESET;
      prescale <= PRESCALE_RESET;
      mask <= STAT_RESET;
    end else if (wp_glob) begin
      // Mode bits are stored only; safe sequencing is up to software
      case (wp_addr)
        REG_RUN: channel_run_reg <= wp_data[NUM_CH-1:0];
        REG_FUNC: function_control_reg <= wp_data[FUNC_W-1:0];
        REG_PRESCALE: prescale <= wp_data[PRESCALE_W-1:0];
        REG_MASK: mask <= wp_data[STAT_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Status and interrupt
  // ---------------------------------------------------------------------
  logic [STAT_W-1:0] st_clr;

  assign st_clr = (wp_glob && wp_addr == REG_STATUS)
    ? wp_data[STAT_W-1:0] : '0;

  // A flag set in the clearing cycle survives
  always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      status <= STAT_RESET;
    end else begin
      status <= (status & ~st_clr) | {ovf_set, match_set};
    end
  end

  assign irq_out = |(status & mask);

  // ---------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------
  logic [CH_W-1:0] rd_ch;
  logic [DATA_W-1:0] next_rdata;

  assign rd_ch = bus_req_in.addr[CH_MSB:CH_LSB];

  always_comb begin
    next_rdata = '0;
    if (bus_req_in.addr[GLOBAL_BIT]) begin
      case (bus_req_in.addr)
        REG_RUN: next_rdata = DATA_W'(channel_run_reg);
        REG_FUNC: next_rdata = DATA_W'(function_control_reg);
        REG_PRESCALE: next_rdata = DATA_W'(prescale);
        REG_STATUS: next_rdata = DATA_W'(status);
        REG_MASK: next_rdata = DATA_W'(mask);
        default: next_rdata = '0;
      endcase
    end else if (rd_ch < CH_W'(NUM_CH)) begin
      case (bus_req_in.addr[REG_MSB:0])
        REG_COUNT: next_rdata = timer_count[rd_ch];
        REG_COUNT_HI: next_rdata = {8'h00, timer_count[rd_ch][15:8]};
        REG_COUNT_LO: next_rdata = {8'h00, timer_count[rd_ch][7:0]};
        REG_GR: next_rdata = compare_capture_reg[rd_ch];
        REG_BR: next_rdata = buffer_reg[rd_ch];
        REG_CTRL: next_rdata = DATA_W'(ctrl[rd_ch]);
        default: next_rdata = '0;
      endcase
    end
  end

  // Sampled before a same-cycle capture lands
  always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      rdata_out <= '0;
    end else if (bus_req_in.rd) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= '0;
    end
  end
endmodule
`default_nettype wire

// ### dv/tac_checker.sv
// Port-level assertions for the timer contention arbiter
`timescale 1ns/10ps
`default_nettype none
module tac_checker (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire tac_pkg::tac_bus_req_type bus_req_in,
  input wire logic [tac_pkg::NUM_CH-1:0] capture_pin_in,
  input wire logic [tac_pkg::DATA_W-1:0] rdata_out,
  input wire logic [tac_pkg::NUM_CH-1:0] compare_match_out,
  input wire logic irq_out
);
  import tac_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire logic wr = bus_req_in.wr;
  wire logic rd = bus_req_in.rd;
  wire logic [ADDR_W-1:0] ad = bus_req_in.addr;
  wire logic chan = !ad[GLOBAL_BIT];
  property p_reset;
    $rose(rstn_in) |-> rdata_out == 16'h0000 && !compare_match_out && !irq_out;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs busy at reset");
  property p_rd_idle;
    !$past(rd) |-> rdata_out == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped;
    rd && chan && ad[7:5] > 3'h4 |=> rdata_out == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_byte_rd;
    rd && chan && (ad[4:0] == REG_COUNT_HI || ad[4:0] == REG_COUNT_LO)
      |=> rdata_out[15:8] == 8'h00;
  endproperty
  a_byte_rd: assert property (p_byte_rd) else $error("byte read too wide");
  property p_func_rd;
    rd && ad == REG_FUNC |=> rdata_out[15:2] == 14'h0000;
  endproperty
  a_func_rd: assert property (p_func_rd) else $error("mode read too wide");
  property p_mask_rw;
    wr && ad == REG_MASK ##1 !wr ##1 rd && ad == REG_MASK
      |=> rdata_out[9:0] == $past(bus_req_in.wdata[9:0], 3);
  endproperty
  a_mask_rw: assert property (p_mask_rw) else $error("mask readback");
  property p_irq_off;
    wr && ad == REG_MASK && bus_req_in.wdata[9:0] == 10'h000 ##1 !wr
      |=> !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  property p_stop;
    wr && ad == REG_RUN && bus_req_in.wdata[4:0] == 5'h00 ##1 !wr [*3]
      |=> compare_match_out == 5'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("match while stopped");
  c_match: cover property (compare_match_out[0]);
  c_irq: cover property (irq_out);
  c_read: cover property (rd ##1 rdata_out != 16'h0000);
endmodule
`default_nettype wire

// ### dv/tac_cpu_model.sv
// Behavioural CPU master on the timer register port
`timescale 1ns/10ps
`default_nettype none
module tac_cpu_model (
  input wire logic clk_in,
  input wire logic [tac_pkg::DATA_W-1:0] rdata_in,
  output var tac_pkg::tac_bus_req_type bus_req_out
);
  import tac_pkg::*;
  initial begin
    bus_req_out = '0;
  end
  // Released lines show inverted values so stale data never looks valid
  task automatic write_reg(input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    bus_req_out <= {1'b1, 1'b0, a, d};
    @(posedge clk_in);
    bus_req_out <= {1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic read_reg(input logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d);
    @(posedge clk_in);
    bus_req_out <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_in);
    bus_req_out <= {1'b0, 1'b0, ~a, 16'hFFFF};
    #1;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the timer contention arbiter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tac_pkg::*;
  logic clk_sys_in;
  logic rstn_in;
  logic [NUM_CH-1:0] capture_pin_in;
  tac_bus_req_type bus_req;
  logic [DATA_W-1:0] rdata;
  logic [NUM_CH-1:0] compare_match;
  logic irq;
  logic [DATA_W-1:0] rd_val;
  int miscompares;
  int tests_run;
  int gap;
  initial clk_sys_in = 1'b0;
  always #20 clk_sys_in = ~clk_sys_in;
  tac_cpu_model cpu (
    .clk_in(clk_sys_in),
    .rdata_in(rdata),
    .bus_req_out(bus_req)
  );
  tac_top uut (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .bus_req_in(bus_req),
    .capture_pin_in(capture_pin_in),
    .rdata_out(rdata),
    .compare_match_out(compare_match),
    .irq_out(irq)
  );
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_reg(input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] exp);
    cpu.read_reg(a, rd_val);
    check(rd_val, exp);
  endtask
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded so a dead compare path ends the run instead of hanging it
  task automatic wait_match(output int cyc);
    cyc = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      cyc++;
    end while (compare_match[0] !== 1'b1 && cyc < 64);
    if (cyc >= 64) begin
      miscompares++;
      $display("mismatch at %0t: no compare match", $time);
      complete_run();
    end
  endtask
  task automatic capture(input int ch);
    @(posedge clk_sys_in);
    capture_pin_in[ch] <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    capture_pin_in[ch] <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    miscompares = 0;
    tests_run = 0;
    rstn_in = 1'b0;
    capture_pin_in = '0;
    repeat (16) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    check_reg(9'h00C, GR_RESET);
    check_reg(9'h000, COUNT_RESET);
    check_reg(9'h0A0, 16'h0000);
    cpu.write_reg(9'h00C, 16'h0003);
    cpu.write_reg(9'h014, 16'h0004);
    cpu.write_reg(REG_RUN, 16'h0001);
    wait_match(gap);
    wait_match(gap);
    check(16'(gap), 16'h0004);
    cpu.write_reg(REG_RUN, 16'h0000);
    repeat (4) @(posedge clk_sys_in);
    cpu.write_reg(9'h034, 16'h0010);
    cpu.write_reg(9'h054, 16'h0010);
    cpu.write_reg(9'h020, 16'h1200);
    cpu.write_reg(9'h028, 16'h00AB);
    check_reg(9'h040, 16'h12AB);
    cpu.write_reg(9'h044, 16'h0034);
    check_reg(9'h020, 16'h34AB);
    check_reg(9'h024, 16'h0034);
    cpu.write_reg(9'h074, 16'h000B);
    cpu.write_reg(REG_MASK, 16'h0008);
    cpu.write_reg(REG_STATUS, 16'h03FF);
    cpu.write_reg(9'h060, 16'h0010);
    capture(3);
    check_reg(9'h06C, 16'h0010);
    check_reg(9'h070, 16'hFFFF);
    check_reg(9'h060, 16'h0000);
    check({15'h0000, irq}, 16'h0001);
    // Capture lands on the tick that would wrap the count
    cpu.write_reg(9'h060, 16'hFFFD);
    cpu.write_reg(REG_RUN, 16'h0008);
    capture(3);
    cpu.write_reg(REG_RUN, 16'h0000);
    check_reg(REG_STATUS, 16'h0008);
    check_reg(9'h06C, 16'hFFFF);
    check_reg(9'h070, 16'h0010);
    // Write commit or read sample lined up with the capture edge
    cpu.write_reg(9'h060, 16'h0777);
    fork
      capture(3);
      begin
        @(posedge clk_sys_in);
        cpu.write_reg(9'h06C, 16'h5555);
      end
    join
    check_reg(9'h06C, 16'h0777);
    cpu.write_reg(9'h060, 16'h0888);
    fork
      capture(3);
      begin
        @(posedge clk_sys_in);
        cpu.write_reg(9'h070, 16'h6666);
      end
    join
    check_reg(9'h070, 16'h0777);
    cpu.write_reg(9'h060, 16'h0999);
    fork
      capture(3);
      begin
        repeat (2) @(posedge clk_sys_in);
        cpu.read_reg(9'h06C, rd_val);
      end
    join
    check(rd_val, 16'h0888);
    check_reg(9'h06C, 16'h0999);
    cpu.write_reg(REG_MASK, 16'h0000);
    check_reg(REG_MASK, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    cpu.write_reg(REG_STATUS, 16'h0008);
    check_reg(REG_STATUS, 16'h0000);
    // First write after a run start commits on the second tick
    cpu.write_reg(9'h080, 16'h12FE);
    cpu.write_reg(REG_RUN, 16'h0010);
    cpu.write_reg(9'h084, 16'h0034);
    cpu.write_reg(REG_RUN, 16'h0000);
    check_reg(9'h080, 16'h3500);
    cpu.write_reg(9'h08C, 16'h1001);
    cpu.write_reg(9'h080, 16'h1000);
    cpu.write_reg(REG_RUN, 16'h0010);
    cpu.write_reg(9'h08C, 16'h2000);
    cpu.write_reg(REG_RUN, 16'h0000);
    check_reg(9'h08C, 16'h2000);
    check_reg(REG_STATUS, 16'h0000);
    cpu.write_reg(9'h080, 16'hFFFE);
    cpu.write_reg(REG_RUN, 16'h0010);
    cpu.write_reg(9'h080, 16'h1000);
    cpu.write_reg(REG_RUN, 16'h0000);
    check_reg(9'h080, 16'h1002);
    check_reg(REG_STATUS, 16'h0200);
    cpu.write_reg(REG_STATUS, 16'h03FF);
    cpu.write_reg(REG_FUNC, 16'h0002);
    check_reg(REG_FUNC, 16'h0002);
    cpu.write_reg(REG_FUNC, 16'h0000);
    check_reg(REG_FUNC, 16'h0000);
    cpu.write_reg(9'h000, 16'h0002);
    cpu.write_reg(REG_RUN, 16'h0001);
    cpu.write_reg(9'h000, 16'h0100);
    cpu.write_reg(REG_RUN, 16'h0000);
    check_reg(9'h000, 16'h0002);
    cpu.write_reg(9'h014, 16'h0000);
    cpu.write_reg(9'h000, 16'hFFFE);
    cpu.write_reg(REG_RUN, 16'h0001);
    repeat (20) @(posedge clk_sys_in);
    cpu.write_reg(REG_RUN, 16'h0000);
    check_reg(REG_STATUS, 16'h0021);
    complete_run();
  end
endmodule
bind tac_top tac_checker chk (
  .clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in),
  .bus_req_in(bus_req_in),
  .capture_pin_in(capture_pin_in),
  .rdata_out(rdata_out),
  .compare_match_out(compare_match_out),
  .irq_out(irq_out)
);
`default_nettype wire
